// File: operand_converter.sv
/*
  operand format converter: moves operands between host memory and eight
  extended-precision data registers, converting format on the way.
  assumes the host answers each memory cycle with mem_ready and holds
  mem_rdata valid in that cycle; one command is handled at a time.
*/
`timescale 1ns/100ps

module operand_converter (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // command port
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire opconv_pkg::req_t       req,
  output logic                        done,
  // host memory bus
  output opconv_pkg::mem_req_t        mem,
  input  wire logic [15:0]            mem_rdata,
  input  wire logic                   mem_ready,
  // register inspection
  output logic [2:0]                  top,
  input  wire logic [2:0]             peek_sel,
  output logic [opconv_pkg::EXT_W-1:0] peek_data
);

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_RD    = 5'b00010,
    S_CVTIN = 5'b00100,
    S_CVTOU = 5'b01000,
    S_WR    = 5'b10000
  } state_t;

  // leading zeros; scanning upward lets the highest set bit have the last word
  function automatic logic [6:0] lzc64(input logic [63:0] v);
    lzc64 = 7'h40;
    for (int i = 0; i < 64; i++)
      if (v[i])
        lzc64 = 7'(63 - i);
  endfunction

  // normalise a magnitude whose integer bit would sit at bit 63 with exponent e0
  function automatic logic [79:0] norm(input logic s, input logic [63:0] mag, input int e0);
    logic [6:0] lz;
    lz = lzc64(mag);
    norm = (mag == 64'h0) ? {s, 79'h0} : {s, 15'(e0 - int'(lz)), mag << lz};
  endfunction

  // memory image to extended
  function automatic logic [79:0] to_ext(input opconv_pkg::fmt_t f, input logic [79:0] b);
    logic [63:0] v;
    logic [63:0] acc;
    v = 64'h0;
    acc = 64'h0;
    case (f)
      opconv_pkg::FMT_INT16, opconv_pkg::FMT_INT32, opconv_pkg::FMT_INT64: begin
        v = (f == opconv_pkg::FMT_INT16) ? {{48{b[15]}}, b[15:0]} :
            (f == opconv_pkg::FMT_INT32) ? {{32{b[31]}}, b[31:0]} : b[63:0];
        to_ext = norm(v[63], v[63] ? -v : v, opconv_pkg::BIAS_EXT + 63);
      end
      opconv_pkg::FMT_FLT32: begin
        if (b[30:23] == 8'h0) // zero or denormal: no hidden bit
          to_ext = norm(b[31], {1'b0, b[22:0], 40'h0}, opconv_pkg::BIAS_EXT - opconv_pkg::BIAS_SGL + 1);
        else if (b[30:23] == opconv_pkg::EXP_SGL_MAX)
          to_ext = {b[31], opconv_pkg::EXP_EXT_MAX, 1'b1, b[22:0], 40'h0};
        else
          to_ext = {b[31], 15'(int'(b[30:23]) - opconv_pkg::BIAS_SGL + opconv_pkg::BIAS_EXT), 1'b1, b[22:0], 40'h0};
      end
      opconv_pkg::FMT_FLT64: begin
        if (b[62:52] == 11'h0)
          to_ext = norm(b[63], {1'b0, b[51:0], 11'h0}, opconv_pkg::BIAS_EXT - opconv_pkg::BIAS_DBL + 1);
        else if (b[62:52] == opconv_pkg::EXP_DBL_MAX)
          to_ext = {b[63], opconv_pkg::EXP_EXT_MAX, 1'b1, b[51:0], 11'h0};
        else
          to_ext = {b[63], 15'(int'(b[62:52]) - opconv_pkg::BIAS_DBL + opconv_pkg::BIAS_EXT), 1'b1, b[51:0], 11'h0};
      end
      opconv_pkg::FMT_BCD80: begin
        // bits 78:72 carry nothing and never reach the sum
        for (int i = opconv_pkg::BCD_DIGITS - 1; i >= 0; i--)
          acc = acc * 64'hA + 64'(b[4*i +: 4]);
        to_ext = norm(b[opconv_pkg::SIGN_BIT], acc, opconv_pkg::BIAS_EXT + 63);
      end
      default: to_ext = b;
    endcase
  endfunction

  // extended to memory image; truncates toward zero, flushes tiny floats to zero
  function automatic logic [79:0] from_ext(input opconv_pkg::fmt_t f, input logic [79:0] x);
    logic        s;
    logic [14:0] e;
    logic [63:0] m;
    logic [63:0] mag;
    logic [63:0] sv;
    logic [71:0] bcd;
    int          sh;
    int          ne;
    s = x[opconv_pkg::SIGN_BIT];
    e = x[78:64];
    m = x[63:0];
    sh = int'(e) - opconv_pkg::BIAS_EXT;
    mag = (sh < 0) ? 64'h0 : (sh > 63 ? 64'hFFFFFFFFFFFFFFFF : m >> (63 - sh));
    sv = s ? -mag : mag;
    bcd = 72'h0;
    case (f)
      // out of range integers answer the most negative code; int64 tests only sh > 62, which catches every magnitude of 2^63 and above
      opconv_pkg::FMT_INT16:
        from_ext = {64'h0, (sh > 62 || mag > (s ? 64'h8000 : 64'h7FFF)) ? 16'h8000 : sv[15:0]};
      opconv_pkg::FMT_INT32:
        from_ext = {48'h0, (sh > 62 || mag > (s ? 64'h80000000 : 64'h7FFFFFFF)) ? 32'h80000000 : sv[31:0]};
      opconv_pkg::FMT_INT64: from_ext = {16'h0, (sh > 62) ? 64'h8000000000000000 : sv};
      opconv_pkg::FMT_FLT32: begin
        ne = int'(e) - opconv_pkg::BIAS_EXT + opconv_pkg::BIAS_SGL;
        if (e == opconv_pkg::EXP_EXT_MAX)
          from_ext = {48'h0, s, opconv_pkg::EXP_SGL_MAX, m[62:40]};
        else if (ne >= int'(opconv_pkg::EXP_SGL_MAX))
          from_ext = {48'h0, s, opconv_pkg::EXP_SGL_MAX, 23'h0};
        else if (ne <= 0 || !m[63])
          from_ext = {48'h0, s, 31'h0};
        else // hidden bit m[63] dropped
          from_ext = {48'h0, s, 8'(ne), m[62:40]};
      end
      opconv_pkg::FMT_FLT64: begin
        ne = int'(e) - opconv_pkg::BIAS_EXT + opconv_pkg::BIAS_DBL;
        if (e == opconv_pkg::EXP_EXT_MAX)
          from_ext = {16'h0, s, opconv_pkg::EXP_DBL_MAX, m[62:11]};
        else if (ne >= int'(opconv_pkg::EXP_DBL_MAX))
          from_ext = {16'h0, s, opconv_pkg::EXP_DBL_MAX, 52'h0};
        else if (ne <= 0 || !m[63])
          from_ext = {16'h0, s, 63'h0};
        else
          from_ext = {16'h0, s, 11'(ne), m[62:11]};
      end
      opconv_pkg::FMT_BCD80: begin
        // shift-add-3 binary to decimal
        for (int i = 63; i >= 0; i--) begin
          for (int j = 0; j < opconv_pkg::BCD_DIGITS; j++)
            if (bcd[4*j +: 4] >= 4'h5)
              bcd[4*j +: 4] = bcd[4*j +: 4] + 4'h3;
          bcd = {bcd[70:0], mag[i]};
        end
        if (sh > 62 || mag > opconv_pkg::BCD_MAX_BIN)
          from_ext = opconv_pkg::BCD_INDEF;
        else
          from_ext = {s, 7'h0, bcd};
      end
      default: from_ext = x;
    endcase
  endfunction

  state_t                                 state_q, state_d;
  opconv_pkg::req_t                       cmd_q, cmd_d;
  logic [opconv_pkg::EXT_W-1:0]           buf_q, buf_d;      // operand image, byte k at bits 8k+7:8k
  logic [3:0]                             pos_q, pos_d;      // bytes moved so far
  logic [2:0]                             top_q, top_d;
  logic                                   done_q, done_d;
  logic [opconv_pkg::EXT_W-1:0]           peek_q, peek_d;
  logic [opconv_pkg::EXT_W-1:0]           regs_q [opconv_pkg::NUM_REGS];
  logic [opconv_pkg::EXT_W-1:0]           wr_val;
  logic                                   wr_en;
  logic [2:0]                             phys;
  logic [2:0]                             push_slot;
  logic [opconv_pkg::ADDR_W-1:0]          cur_addr;
  logic [3:0]                             left;
  logic [1:0]                             be;
  logic [opconv_pkg::EXT_W-1:0]           buf_sh;

  // bus cycle shape: odd byte alone on the high lane, then whole words, a last leftover byte alone on the low lane
  always_comb begin
    cur_addr = cmd_q.addr + opconv_pkg::ADDR_W'(pos_q);
    left = opconv_pkg::fmt_bytes(cmd_q.fmt) - pos_q;
    be = cur_addr[0] ? opconv_pkg::BE_HI : ((left >= 4'h2) ? opconv_pkg::BE_WORD : opconv_pkg::BE_LO);
    buf_sh = buf_q >> {pos_q, 3'h0};
    // stack-relative index counts from top; a pushing load lands one below
    phys = cmd_q.stack_rel ? 3'(top_q + cmd_q.reg_idx) : cmd_q.reg_idx;
    push_slot = 3'(top_q - 3'h1);
  end

  assign req_ready = (state_q == S_IDLE);
  assign done      = done_q;
  assign top       = top_q;
  assign peek_data = peek_q;

  always_comb begin
    mem = '0;
    mem.addr = {cur_addr[opconv_pkg::ADDR_W-1:1], 1'b0};
    mem.be = be;
    mem.rd = (state_q == S_RD);
    mem.wr = (state_q == S_WR);
    // a lone byte rides its own lane; the other lane is driven zero
    mem.wdata = (be == opconv_pkg::BE_HI) ? {buf_sh[7:0], 8'h00} :
                (be == opconv_pkg::BE_LO) ? {8'h00, buf_sh[7:0]} : buf_sh[15:0];
  end

  // sequencing and conversion
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    buf_d = buf_q;
    pos_d = pos_q;
    top_d = top_q;
    done_d = 1'b0;
    wr_en = 1'b0;
    wr_val = to_ext(cmd_q.fmt, buf_q);
    peek_d = regs_q[peek_sel];
    case (state_q)
      S_IDLE: begin
        if (req_valid) begin
          cmd_d = req;
          pos_d = 4'h0;
          buf_d = '0;
          state_d = req.store ? S_CVTOU : S_RD;
        end
      end
      S_RD: begin
        if (mem_ready) begin
          buf_d[{pos_q, 3'h0} +: 8] = (be == opconv_pkg::BE_HI) ? mem_rdata[15:8] : mem_rdata[7:0];
          if (be == opconv_pkg::BE_WORD)
            buf_d[{4'(pos_q + 4'h1), 3'h0} +: 8] = mem_rdata[15:8];
          pos_d = pos_q + ((be == opconv_pkg::BE_WORD) ? 4'h2 : 4'h1);
          if (left <= ((be == opconv_pkg::BE_WORD) ? 4'h2 : 4'h1))
            state_d = S_CVTIN;
        end
      end
      S_CVTIN: begin
        wr_en = 1'b1;
        top_d = (cmd_q.stack_rel && cmd_q.push_pop) ? push_slot : top_q;
        state_d = S_IDLE;
        done_d = 1'b1;
      end
      S_CVTOU: begin
        buf_d = from_ext(cmd_q.fmt, regs_q[phys]);
        state_d = S_WR;
      end
      S_WR: begin
        if (mem_ready) begin
          pos_d = pos_q + ((be == opconv_pkg::BE_WORD) ? 4'h2 : 4'h1);
          if (left <= ((be == opconv_pkg::BE_WORD) ? 4'h2 : 4'h1)) begin
            top_d = (cmd_q.stack_rel && cmd_q.push_pop) ? 3'(top_q + 3'h1) : top_q; // pop once the value has left
            state_d = S_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // sequencer registers; reset returns to idle with an empty stack pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cmd_q <= '0;
      buf_q <= '0;
      pos_q <= 4'h0;
      top_q <= 3'h0;
      done_q <= 1'b0;
      peek_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      buf_q <= buf_d;
      pos_q <= pos_d;
      top_q <= top_d;
      done_q <= done_d;
      peek_q <= peek_d;
    end
  end

  // register file; a pushing load writes the slot below the old top
  for (genvar r = 0; r < opconv_pkg::NUM_REGS; r++) begin : g_reg
    logic [opconv_pkg::EXT_W-1:0] reg_d;
    always_comb begin
      reg_d = regs_q[r];
      if (wr_en && 3'(r) == ((cmd_q.stack_rel && cmd_q.push_pop) ? push_slot : phys))
        reg_d = wr_val;
    end
    always_ff @(posedge clk) begin
      if (!rst_n)
        regs_q[r] <= '0;
      else
        regs_q[r] <= reg_d;
    end
  end

endmodule

// File: opconv_pkg.sv
/*
  constants, formats and carrier types for the operand format converter.
  assumes a 20-bit byte address space reached over a 16-bit little-endian word bus.
*/
package opconv_pkg;

  // extended-precision layout
  localparam int EXT_W      = 80;
  localparam int SIGN_BIT   = 79;
  localparam int EXP_W      = 15;
  localparam int MANT_W     = 64;
  localparam int BIAS_SGL   = 127;
  localparam int BIAS_DBL   = 1023;
  localparam int BIAS_EXT   = 16383;
  localparam int NUM_REGS   = 8;
  localparam int BCD_DIGITS = 18;
  localparam int ADDR_W     = 20;

  // exponent all-ones codes
  localparam logic [14:0] EXP_EXT_MAX = 15'h7FFF;
  localparam logic [7:0]  EXP_SGL_MAX = 8'hFF;
  localparam logic [10:0] EXP_DBL_MAX = 11'h7FF;

  // answers for values a store cannot represent
  localparam logic [79:0] BCD_INDEF   = 80'hFFFFC000000000000000;
  localparam logic [63:0] BCD_MAX_BIN = 64'h0DE0B6B3A763FFFF;

  // byte lanes of one bus word
  localparam logic [1:0] BE_LO   = 2'h1;
  localparam logic [1:0] BE_HI   = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;

  typedef enum logic [2:0] {
    FMT_INT16 = 3'h0,
    FMT_INT32 = 3'h1,
    FMT_INT64 = 3'h2,
    FMT_FLT32 = 3'h3,
    FMT_FLT64 = 3'h4,
    FMT_BCD80 = 3'h5,
    FMT_EXT80 = 3'h6
  } fmt_t;

  // one load or store command
  typedef struct packed {
    logic              store;      // 1: register to memory
    fmt_t              fmt;
    logic [ADDR_W-1:0] addr;       // lowest byte address of the operand
    logic              stack_rel;  // 1: index counts from top of stack
    logic [2:0]        reg_idx;
    logic              push_pop;   // load pushes, store pops (stack mode)
  } req_t;

  // memory cycle driven to the host bus
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;       // always word aligned
    logic [1:0]        be;
    logic [15:0]       wdata;
  } mem_req_t;

  function automatic logic [3:0] fmt_bytes(input fmt_t f);
    case (f)
      FMT_INT16: fmt_bytes = 4'h2;
      FMT_INT32: fmt_bytes = 4'h4;
      FMT_FLT32: fmt_bytes = 4'h4;
      FMT_INT64: fmt_bytes = 4'h8;
      FMT_FLT64: fmt_bytes = 4'h8;
      default:   fmt_bytes = 4'hA;
    endcase
  endfunction

endpackage

// File: opconv_asserts.sv
/*
  protocol assertions for the operand converter, bound to its top module.
  assumes a single clock domain with synchronous active-low reset.
*/
`timescale 1ns/100ps

module opconv_asserts (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // command port
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire opconv_pkg::req_t  req,
  input wire logic              done,
  // host memory bus and stack pointer
  input wire opconv_pkg::mem_req_t mem,
  input wire logic              mem_ready,
  input wire logic [2:0]        top
);
  logic       take;
  logic       push_d;
  logic       push_q;
  logic [2:0] top_d;
  logic [2:0] top_q;

  assign take = req_valid && req_ready;

  // remember kind of command and pointer at take, for the push check
  always_comb begin
    push_d = push_q;
    top_d  = top_q;
    if (take) begin
      push_d = !req.store && req.stack_rel && req.push_pop;
      top_d  = top;
    end
  end

  // helper registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      top_q  <= 3'h0;
    end else begin
      push_q <= push_d;
      top_q  <= top_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_bus_wait;
    (mem.rd || mem.wr) && !mem_ready;
  endsequence

  AST_DONE_BOUND: assert property (s_take |-> ##[2:200] done)
    else $error("command not finished in time");
  AST_BUSY_AFTER_TAKE: assert property (s_take |=> !req_ready)
    else $error("ready stayed high after take");
  AST_IDLE_QUIET: assert property (s_take |-> !mem.rd && !mem.wr)
    else $error("bus active while idle");
  AST_BUS_HOLD: assert property (s_bus_wait |=> $stable(mem))
    else $error("bus cycle changed before ready");
  AST_WORD_ALIGN: assert property ((mem.rd || mem.wr) |-> !mem.addr[0])
    else $error("bus address not word aligned");
  AST_LANES: assert property ((mem.rd || mem.wr) |-> mem.be != 2'h0)
    else $error("bus cycle with no byte lane");
  AST_ONE_DIR: assert property (!(mem.rd && mem.wr))
    else $error("read and write together");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_PUSH_TOP: assert property (done && push_q |-> top == top_q - 3'h1)
    else $error("push did not lower the top pointer");
endmodule

bind operand_converter opconv_asserts u_chk (
  .clk       (clk),
  .rst_n     (rst_n),
  .req_valid (req_valid),
  .req_ready (req_ready),
  .req       (req),
  .done      (done),
  .mem       (mem),
  .mem_ready (mem_ready),
  .top       (top)
);

// File: host_mem_model.sv
/*
  behavioural host memory: 256 bytes, little endian, answers each bus cycle
  after a chosen number of wait cycles. assumes word-aligned bus addresses.
*/
`timescale 1ns/100ps

module host_mem_model (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // bus from the converter
  input wire opconv_pkg::mem_req_t mem,
  output logic [15:0]              mem_rdata = 16'h0,
  output logic                     mem_ready = 1'b0,
  // wait cycles before each answer
  input wire logic [1:0]           slow
);
  logic [7:0] m [256];
  logic [1:0] cnt;
  logic [7:0] a;

  assign a = mem.addr[7:0];

  // read data toggles outside ready so stale data never looks valid
  always @(posedge clk) begin
    mem_ready <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      cnt       <= 2'h0;
      mem_rdata <= 16'h0;
    end else if ((mem.rd || mem.wr) && !mem_ready) begin
      if (cnt < slow) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt       <= 2'h0;
        mem_ready <= 1'b1;
        if (mem.rd) mem_rdata <= {m[a + 8'h1], m[a]};
        if (mem.wr && mem.be[0]) m[a] <= mem.wdata[7:0];
        if (mem.wr && mem.be[1]) m[a + 8'h1] <= mem.wdata[15:8];
      end
    end
  end
endmodule

// File: tb.sv
/*
  self-checking bench for the operand converter: loads and stores of every
  format, odd addresses, slow host, stack access. assumes host_mem_model.
*/
`timescale 1ns/100ps

module tb;
  logic                 clk       = 1'b0;
  logic                 rst_n     = 1'b0;
  logic                 req_valid = 1'b0;
  opconv_pkg::req_t     req       = '0;
  logic [2:0]           peek_sel  = 3'h0;
  logic [1:0]           slow      = 2'h0;
  logic                 req_ready;
  logic                 done;
  logic                 mem_ready;
  logic [2:0]           top;
  logic [15:0]          mem_rdata;
  logic [79:0]          peek_data;
  opconv_pkg::mem_req_t mem;
  int                   errors       = 0;
  int                   total_checks = 0;
  int                   ncyc         = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // count completed bus cycles of the current command
  always @(posedge clk) if (mem_ready && (mem.rd || mem.wr)) ncyc <= ncyc + 1;

  operand_converter dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .done(done), .mem(mem), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .top(top), .peek_sel(peek_sel), .peek_data(peek_data));
  host_mem_model u_host (.clk(clk), .rst_n(rst_n), .mem(mem), .mem_rdata(mem_rdata),
    .mem_ready(mem_ready), .slow(slow));

  task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one command, then wait for done under a bound
  task automatic run(input logic st, input int f, input logic [7:0] a, input logic sr,
                     input logic [2:0] idx, input logic pp);
    int n;
    n = 0;
    @(posedge clk);
    ncyc      <= 0;
    req_valid <= 1'b1;
    req <= '{store:st, fmt:opconv_pkg::fmt_t'(f), addr:{12'h0, a}, stack_rel:sr, reg_idx:idx, push_pop:pp};
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 300);
    chk("done", 96'(done), 96'h1);
  endtask

  task automatic peek(input logic [2:0] i, output logic [79:0] v);
    @(posedge clk);
    peek_sel <= i;
    repeat (2) @(posedge clk);
    #1;
    v = peek_data;
  endtask

  // byte k of a value sits at address a+k
  task automatic put(input int a, input int n, input logic [95:0] v);
    for (int k = 0; k < n; k++) u_host.m[8'(a + k)] = v[8*k +: 8];
  endtask
  task automatic get(input int a, input int n, output logic [95:0] v);
    v = '0;
    for (int k = 0; k < n; k++) v[8*k +: 8] = u_host.m[8'(a + k)];
  endtask

  task automatic t_reset;
    logic [79:0] v;
    chk("ready", 96'(req_ready), 96'h1);
    chk("top", 96'(top), 96'h0);
    peek(3'h4, v);
    chk("reg", 96'(v), 96'h0);
  endtask

  // every format into registers 0..6, odd starts and slow host mixed in
  task automatic t_loads;
    logic [79:0] v;
    logic [79:0] src [7] = '{80'hFFFE, 80'h186A0, 80'hFFFFFFFFFFFFFFFF, 80'h3FC00000,
      80'hBFE8000000000000, 80'hFF000000000000000012, 80'h4005ABCD1234567890EF};
    logic [79:0] ex [7] = '{80'hC0008000000000000000, 80'h400FC350000000000000,
      80'hBFFF8000000000000000, 80'h3FFFC000000000000000, 80'hBFFEC000000000000000,
      80'hC002C000000000000000, 80'h4005ABCD1234567890EF};
    int ad [7] = '{'h10, 'h13, 'h20, 'h29, 'h30, 'h39, 'h44};
    int nb [7] = '{2, 4, 8, 4, 8, 10, 10};
    int cy [7] = '{1, 3, 4, 3, 4, 6, 5};
    for (int i = 0; i < 7; i++) begin
      put(ad[i], nb[i], 96'(src[i]));
      slow <= 2'(i);
      run(1'b0, i, 8'(ad[i]), 1'b0, 3'(i), 1'b0);
      chk("load cycles", 96'(ncyc), 96'(cy[i]));
      peek(3'(i), v);
      chk("load value", 96'(v), 96'(ex[i]));
    end
    slow <= 2'h0;
  endtask

  // every format back out, with guard bytes around each operand
  task automatic t_stores;
    logic [95:0] v;
    logic [95:0] e;
    logic [79:0] val [7] = '{80'hFFFE, 80'hFFFFFFFE, 80'h186A0, 80'hBF800000,
      80'h3FF8000000000000, 80'h80000000000000000012, 80'h4005ABCD1234567890EF};
    int ad [7] = '{'h61, 'h65, 'h6A, 'h74, 'h50, 'h79, 'h86};
    int rg [7] = '{0, 0, 1, 2, 3, 5, 6};
    int nb [7] = '{2, 4, 8, 4, 8, 10, 10};
    int cy [7] = '{2, 3, 4, 2, 4, 6, 5};
    for (int i = 0; i < 7; i++) begin
      put(ad[i] - 1, nb[i] + 2, {12{8'hAA}});
      slow <= 2'(3 - i);
      run(1'b1, i, 8'(ad[i]), 1'b0, 3'(rg[i]), 1'b0);
      for (int k = 0; k < 12; k++) e[8*k +: 8] = (k == 0 || k > nb[i]) ? 8'hAA : val[i][8*(k-1) +: 8];
      get(ad[i] - 1, nb[i] + 2, v);
      chk("store bytes", v, e & ~({96{1'b1}} << (8 * (nb[i] + 2))));
      chk("store cycles", 96'(ncyc), 96'(cy[i]));
    end
    slow <= 2'h0;
  endtask

  // push, stack-relative load and pop through the register stack
  task automatic t_stack;
    logic [79:0] v;
    logic [95:0] m;
    put('h90, 2, 96'h0005);
    run(1'b0, 0, 8'h90, 1'b1, 3'h0, 1'b1);
    chk("top after push", 96'(top), 96'h7);
    peek(3'h7, v);
    chk("pushed value", 96'(v), 96'h4001A000000000000000);
    run(1'b0, 0, 8'h90, 1'b1, 3'h2, 1'b0);
    peek(3'h1, v);
    chk("relative value", 96'(v), 96'h4001A000000000000000);
    run(1'b1, 0, 8'h92, 1'b1, 3'h0, 1'b1);
    get('h92, 2, m);
    chk("popped value", m, 96'h0005);
    chk("top after pop", 96'(top), 96'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset;
    t_loads;
    t_stores;
    t_stack;
    end_of_test;
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test;
  end
endmodule
